//--- design/dpsr_defs.vh
// Shared constants of the dual-port synchronous RAM
`ifndef DPSR_DEFS_VH
`define DPSR_DEFS_VH

// Word and depth
`define DPSR_AW 19
`define DPSR_DW 18
`define DPSR_LANE 9

// Registered pin controls, bit positions in the control vector
`define DPSR_CTL_W 10
`define DPSR_CTL_CE 9
`define DPSR_CTL_RW 8
`define DPSR_CTL_BEN_HI 7
`define DPSR_CTL_BEN_LO 6
`define DPSR_CTL_STB 5
`define DPSR_CTL_CEN 4
`define DPSR_CTL_CRST 3
`define DPSR_CTL_MSEL 2
`define DPSR_CTL_RB 1
`define DPSR_CTL_RT 0
`define DPSR_CTL_IDLE 10'h1fb

// Register map, byte addresses
`define DPSR_AXI_AW 8
`define DPSR_OFS_STATUS 8'h00
`define DPSR_OFS_IRQ_MASK 8'h04
`define DPSR_OFS_PORT_STATE 8'h08

// Status and mask fields
`define DPSR_EV_W 2
`define DPSR_EV_WRAP_A 0
`define DPSR_EV_WRAP_B 1

// Port state fields
`define DPSR_ST_PD_A 0
`define DPSR_ST_PD_B 1
`define DPSR_ST_WRAP_A 2
`define DPSR_ST_WRAP_B 3

// Bus responses
`define DPSR_RESP_OKAY 2'h0
`define DPSR_RESP_SLVERR 2'h2

`endif

//--- design/dpsr_port.v
// One memory port: input registers, burst counter, mask, wrap flag, power-down
`include "dpsr_defs.vh"
module dpsr_port #(
   parameter AW = `DPSR_AW
) (
   // Clock and resets
   input wire clk,
   input wire rst,
   input wire global_async_reset,
   // Port pins
   input wire [AW-1:0] addr_in,
   input wire [`DPSR_DW-1:0] data_in,
   input wire read_write,
   input wire [1:0] byte_en_n,
   input wire chip_enable_active_low,
   input wire chip_enable_active_high,
   input wire address_strobe_n,
   input wire count_enable_n,
   input wire counter_reset_n,
   input wire mask_select,
   input wire readback_n,
   input wire retransmit_n,
   // Readback and status
   output reg [AW-1:0] addr_out_q,
   output reg addr_oe_q,
   output reg counter_wrap_flag_q,
   output reg power_down_q,
   // Memory side
   output wire [AW-1:0] mem_addr,
   output wire [`DPSR_DW-1:0] mem_wdata,
   output wire [1:0] mem_lane_en,
   output wire mem_we,
   output wire mem_rd
);
   localparam [AW-1:0] ZERO = {AW{1'b0}};
   localparam [AW-1:0] ONES = {AW{1'b1}};
   localparam [AW-1:0] ONE = {{(AW-1){1'b0}}, 1'b1};

   reg [`DPSR_CTL_W-1:0] ctl_q, ctl_d;
   reg [AW-1:0] ain_q, cnt_q, cnt_d, base_q, base_d, mask_q, mask_d, cur, aout_d;
   reg [`DPSR_DW-1:0] din_q;
   reg wrap_d, aoe_d, access;

   always @* begin
      ctl_d = {chip_enable_active_high & ~chip_enable_active_low, read_write, byte_en_n,
         address_strobe_n, count_enable_n, counter_reset_n, mask_select, readback_n,
         retransmit_n};
      cnt_d = cnt_q;
      base_d = base_q;
      mask_d = mask_q;
      wrap_d = counter_wrap_flag_q;
      aout_d = addr_out_q;
      aoe_d = 1'b0;
      access = 1'b0;
      // Retransmit restarts the burst inside the masked block
      if (!ctl_q[`DPSR_CTL_RT]) begin
         cur = (cnt_q & ~mask_q) | (base_q & mask_q);
      end else if (!ctl_q[`DPSR_CTL_STB]) begin
         cur = ain_q;
      end else begin
         cur = cnt_q;
      end
      if (ctl_q[`DPSR_CTL_CE]) begin
         if (!ctl_q[`DPSR_CTL_CRST]) begin
            if (ctl_q[`DPSR_CTL_MSEL]) begin
               mask_d = ONES;
            end else begin
               cnt_d = ZERO;
               wrap_d = 1'b0;
            end
         end else if (ctl_q[`DPSR_CTL_MSEL] && !ctl_q[`DPSR_CTL_STB]) begin
            mask_d = ain_q;
         end else if (!ctl_q[`DPSR_CTL_RB]) begin
            aout_d = ctl_q[`DPSR_CTL_MSEL] ? mask_q : cnt_q;
            aoe_d = 1'b1;
         end else begin
            access = 1'b1;
            if (!ctl_q[`DPSR_CTL_STB] && ctl_q[`DPSR_CTL_RT]) begin
               base_d = ain_q;
               wrap_d = 1'b0;
            end
            cnt_d = cur;
            if (!ctl_q[`DPSR_CTL_CEN]) begin
               cnt_d = (cur & ~mask_q) | ((cur + ONE) & mask_q);
               if ((cur & mask_q) == mask_q) begin
                  wrap_d = 1'b1;
               end
            end
         end
      end
      if (rst) begin
         ctl_d = `DPSR_CTL_IDLE;
         cnt_d = ZERO;
         base_d = ZERO;
         mask_d = ONES;
         wrap_d = 1'b0;
         aout_d = ZERO;
         aoe_d = 1'b0;
      end
   end

   // Global reset acts at once, without a clock edge
   always @(posedge clk or posedge global_async_reset) begin
      if (global_async_reset) begin
         ctl_q <= `DPSR_CTL_IDLE;
         ain_q <= ZERO;
         din_q <= {`DPSR_DW{1'b0}};
         cnt_q <= ZERO;
         base_q <= ZERO;
         mask_q <= ONES;
         counter_wrap_flag_q <= 1'b0;
         power_down_q <= 1'b1;
         addr_out_q <= ZERO;
         addr_oe_q <= 1'b0;
      end else begin
         ctl_q <= ctl_d;
         ain_q <= addr_in;
         din_q <= data_in;
         cnt_q <= cnt_d;
         base_q <= base_d;
         mask_q <= mask_d;
         counter_wrap_flag_q <= wrap_d;
         power_down_q <= rst | ~ctl_q[`DPSR_CTL_CE];
         addr_out_q <= aout_d;
         addr_oe_q <= aoe_d;
      end
   end

   // One write pulse per sampled cycle, independent of how long the select is held
   assign mem_we = access & ~ctl_q[`DPSR_CTL_RW] & ~rst;
   assign mem_rd = access & ctl_q[`DPSR_CTL_RW] & ~rst;
   assign mem_addr = cur;
   assign mem_wdata = din_q;
   assign mem_lane_en = ~ctl_q[`DPSR_CTL_BEN_HI:`DPSR_CTL_BEN_LO];

endmodule

//--- design/dpsr_top.v
// Dual-port synchronous RAM with two pin ports and an AXI4-Lite status slave
`include "dpsr_defs.vh"
//
// Overview of operation
// - Both ports read or write any word independently, same cycle, same word too.
// - Read data passes an output register before the data pins.
// - Each port has a loadable burst counter that advances the address internally.
// - Internal write pulse is self-timed, independent of read/write hold time.
// - Either chip enable inactive for one cycle powers the port down.
// - Outputs return only after one sampled cycle with both enables asserted.
// - Words are 18 bits; 17, 18 or 19 address bits per port.
// - Each port has its own byte lane enables.
// - A mask register limits counting so bursts wrap inside a block.
// - Each port raises a wrap flag when its counter wraps.
// - Counter value can be read back on the address lines.
// - Mask value can be read back on the address lines.
// - An asynchronous global reset acts on both ports without a clock.
// - Retransmit repeats a burst over the same masked block.
module dpsr_top #(
   parameter AW = `DPSR_AW
) (
   // Clock and resets
   input wire clk,
   input wire rst,
   input wire global_async_reset,
   // AXI4-Lite write channels
   input wire [`DPSR_AXI_AW-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read channels
   input wire [`DPSR_AXI_AW-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Interrupt
   output reg irq,
   // Port A pins
   input wire [AW-1:0] a_addr_in,
   output wire [AW-1:0] a_addr_out,
   output wire a_addr_oe,
   input wire [`DPSR_DW-1:0] a_data_in,
   output reg [`DPSR_DW-1:0] a_data_out,
   output reg a_data_oe,
   input wire a_read_write,
   input wire [1:0] a_byte_en_n,
   input wire a_chip_enable_active_low,
   input wire a_chip_enable_active_high,
   input wire a_address_strobe_n,
   input wire a_count_enable_n,
   input wire a_counter_reset_n,
   input wire a_mask_select,
   input wire a_readback_n,
   input wire a_retransmit_n,
   output wire a_counter_wrap_flag,
   // Port B pins
   input wire [AW-1:0] b_addr_in,
   output wire [AW-1:0] b_addr_out,
   output wire b_addr_oe,
   input wire [`DPSR_DW-1:0] b_data_in,
   output reg [`DPSR_DW-1:0] b_data_out,
   output reg b_data_oe,
   input wire b_read_write,
   input wire [1:0] b_byte_en_n,
   input wire b_chip_enable_active_low,
   input wire b_chip_enable_active_high,
   input wire b_address_strobe_n,
   input wire b_count_enable_n,
   input wire b_counter_reset_n,
   input wire b_mask_select,
   input wire b_readback_n,
   input wire b_retransmit_n,
   output wire b_counter_wrap_flag
);
   localparam DEPTH = 1 << AW;
   localparam L = `DPSR_LANE;

   // Memory side of each port
   wire [AW-1:0] a_mem_addr, b_mem_addr;
   wire [`DPSR_DW-1:0] a_mem_wdata, b_mem_wdata;
   wire [1:0] a_mem_lane, b_mem_lane;
   wire a_mem_we, b_mem_we, a_mem_rd, b_mem_rd;
   wire a_pd, b_pd;

   reg [`DPSR_DW-1:0] mem [0:DEPTH-1];

   dpsr_port #(
      .AW(AW)
   ) u_port_a (
      .clk(clk),
      .rst(rst),
      .global_async_reset(global_async_reset),
      .addr_in(a_addr_in),
      .data_in(a_data_in),
      .read_write(a_read_write),
      .byte_en_n(a_byte_en_n),
      .chip_enable_active_low(a_chip_enable_active_low),
      .chip_enable_active_high(a_chip_enable_active_high),
      .address_strobe_n(a_address_strobe_n),
      .count_enable_n(a_count_enable_n),
      .counter_reset_n(a_counter_reset_n),
      .mask_select(a_mask_select),
      .readback_n(a_readback_n),
      .retransmit_n(a_retransmit_n),
      .addr_out_q(a_addr_out),
      .addr_oe_q(a_addr_oe),
      .counter_wrap_flag_q(a_counter_wrap_flag),
      .power_down_q(a_pd),
      .mem_addr(a_mem_addr),
      .mem_wdata(a_mem_wdata),
      .mem_lane_en(a_mem_lane),
      .mem_we(a_mem_we),
      .mem_rd(a_mem_rd)
   );

   dpsr_port #(
      .AW(AW)
   ) u_port_b (
      .clk(clk),
      .rst(rst),
      .global_async_reset(global_async_reset),
      .addr_in(b_addr_in),
      .data_in(b_data_in),
      .read_write(b_read_write),
      .byte_en_n(b_byte_en_n),
      .chip_enable_active_low(b_chip_enable_active_low),
      .chip_enable_active_high(b_chip_enable_active_high),
      .address_strobe_n(b_address_strobe_n),
      .count_enable_n(b_count_enable_n),
      .counter_reset_n(b_counter_reset_n),
      .mask_select(b_mask_select),
      .readback_n(b_readback_n),
      .retransmit_n(b_retransmit_n),
      .addr_out_q(b_addr_out),
      .addr_oe_q(b_addr_oe),
      .counter_wrap_flag_q(b_counter_wrap_flag),
      .power_down_q(b_pd),
      .mem_addr(b_mem_addr),
      .mem_wdata(b_mem_wdata),
      .mem_lane_en(b_mem_lane),
      .mem_we(b_mem_we),
      .mem_rd(b_mem_rd)
   );

   // Both ports reach the array in the same cycle; port B is written last
   always @(posedge clk) begin
      if (a_mem_we && a_mem_lane[0]) begin
         mem[a_mem_addr][L-1:0] <= a_mem_wdata[L-1:0];
      end
      if (a_mem_we && a_mem_lane[1]) begin
         mem[a_mem_addr][`DPSR_DW-1:L] <= a_mem_wdata[`DPSR_DW-1:L];
      end
      if (b_mem_we && b_mem_lane[0]) begin
         mem[b_mem_addr][L-1:0] <= b_mem_wdata[L-1:0];
      end
      if (b_mem_we && b_mem_lane[1]) begin
         mem[b_mem_addr][`DPSR_DW-1:L] <= b_mem_wdata[`DPSR_DW-1:L];
      end
   end

   // Registered read data; a read of a word being written returns the old value
   always @(posedge clk) begin
      if (a_mem_rd) begin
         a_data_out <= mem[a_mem_addr];
      end
      if (b_mem_rd) begin
         b_data_out <= mem[b_mem_addr];
      end
   end

   // Data drivers come back only after a read sampled with both enables asserted
   always @(posedge clk or posedge global_async_reset) begin
      if (global_async_reset) begin
         a_data_oe <= 1'b0;
         b_data_oe <= 1'b0;
      end else begin
         a_data_oe <= a_mem_rd & ~rst;
         b_data_oe <= b_mem_rd & ~rst;
      end
   end

   // Wrap events and interrupt registers
   reg [`DPSR_EV_W-1:0] status_q, status_d, irq_mask_q, irq_mask_d, wrap_prev_q;
   wire [`DPSR_EV_W-1:0] wrap_now = {b_counter_wrap_flag, a_counter_wrap_flag};
   wire [`DPSR_EV_W-1:0] wrap_rise = wrap_now & ~wrap_prev_q;

   // Write channel state
   reg [`DPSR_AXI_AW-1:0] waddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg aw_have_q, w_have_q;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire aw_ok = aw_have_q | aw_take;
   wire w_ok = w_have_q | w_take;
   wire [`DPSR_AXI_AW-1:0] wr_addr = aw_have_q ? waddr_q : s_axi_awaddr;
   wire [31:0] wr_data = w_have_q ? wdata_q : s_axi_wdata;
   wire [3:0] wr_strb = w_have_q ? wstrb_q : s_axi_wstrb;
   wire wr_go = aw_ok & w_ok & ~s_axi_bvalid;
   wire wr_hit = (wr_addr == `DPSR_OFS_STATUS) || (wr_addr == `DPSR_OFS_IRQ_MASK) ||
      (wr_addr == `DPSR_OFS_PORT_STATE);

   // Register writes; a wrap event in the clearing cycle stays set
   always @* begin
      status_d = status_q;
      irq_mask_d = irq_mask_q;
      if (wr_go && wr_strb[0]) begin
         if (wr_addr == `DPSR_OFS_STATUS) begin
            status_d = status_q & ~wr_data[`DPSR_EV_W-1:0];
         end
         if (wr_addr == `DPSR_OFS_IRQ_MASK) begin
            irq_mask_d = wr_data[`DPSR_EV_W-1:0];
         end
      end
      status_d = status_d | wrap_rise;
   end

   always @(posedge clk) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DPSR_RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         waddr_q <= {`DPSR_AXI_AW{1'b0}};
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         status_q <= {`DPSR_EV_W{1'b0}};
         irq_mask_q <= {`DPSR_EV_W{1'b0}};
         wrap_prev_q <= {`DPSR_EV_W{1'b0}};
         irq <= 1'b0;
      end else begin
         status_q <= status_d;
         irq_mask_q <= irq_mask_d;
         wrap_prev_q <= wrap_now;
         irq <= |(status_q & irq_mask_q);
         if (aw_take) begin
            waddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         aw_have_q <= aw_ok & ~wr_go;
         w_have_q <= w_ok & ~wr_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `DPSR_RESP_OKAY : `DPSR_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read channel
   reg [31:0] rd_val;
   reg rd_hit;

   always @* begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `DPSR_OFS_STATUS: begin
            rd_val[`DPSR_EV_W-1:0] = status_q;
         end
         `DPSR_OFS_IRQ_MASK: begin
            rd_val[`DPSR_EV_W-1:0] = irq_mask_q;
         end
         `DPSR_OFS_PORT_STATE: begin
            rd_val[`DPSR_ST_PD_A] = a_pd;
            rd_val[`DPSR_ST_PD_B] = b_pd;
            rd_val[`DPSR_ST_WRAP_A] = a_counter_wrap_flag;
            rd_val[`DPSR_ST_WRAP_B] = b_counter_wrap_flag;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `DPSR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? `DPSR_RESP_OKAY : `DPSR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

//--- test/dpsr_checker.sv
// Port-level timing checks of the dual-port RAM
module dpsr_checker (
   // Clock and resets
   input wire clk,
   input wire rst,
   input wire global_async_reset,
   // Port A
   input wire a_read_write,
   input wire a_chip_enable_active_low,
   input wire a_chip_enable_active_high,
   input wire a_address_strobe_n,
   input wire a_count_enable_n,
   input wire a_counter_reset_n,
   input wire a_readback_n,
   input wire a_data_oe,
   input wire a_addr_oe,
   input wire a_counter_wrap_flag,
   // Port B
   input wire b_read_write,
   input wire b_chip_enable_active_low,
   input wire b_chip_enable_active_high,
   input wire b_count_enable_n,
   input wire b_data_oe,
   input wire b_addr_oe,
   input wire b_counter_wrap_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst || global_async_reset);
   wire a_on = a_chip_enable_active_high && !a_chip_enable_active_low;
   wire b_on = b_chip_enable_active_high && !b_chip_enable_active_low;
   wire a_rd = a_on && a_read_write;
   wire b_rd = b_on && b_read_write;
   wire a_inc = a_on && !a_count_enable_n;
   wire b_inc = b_on && !b_count_enable_n;
   wire a_rb = a_on && !a_readback_n;
   a_read_source: assert property (a_data_oe |-> $past(a_rd, 2))
      else $error("port A read data without a read request");
   a_b_read_source: assert property (b_data_oe |-> $past(b_rd, 2))
      else $error("port B read data without a read request");
   a_pd_quiet: assert property (!a_on |-> ##2 !a_data_oe && !a_addr_oe)
      else $error("port A drives outputs after a disabled cycle");
   a_b_pd_quiet: assert property (!b_on |-> ##2 !b_data_oe && !b_addr_oe)
      else $error("port B drives outputs after a disabled cycle");
   a_wrap_hold: assert property (a_counter_wrap_flag && $past(a_address_strobe_n)
      && $past(a_counter_reset_n) |=> a_counter_wrap_flag)
      else $error("port A wrap flag dropped without load or reset");
   a_wrap_cause: assert property ($rose(a_counter_wrap_flag) |-> $past(a_inc, 2))
      else $error("port A wrap flag rose without counting");
   a_b_wrap_cause: assert property ($rose(b_counter_wrap_flag) |-> $past(b_inc, 2))
      else $error("port B wrap flag rose without counting");
   a_rb_source: assert property (a_addr_oe |-> $past(a_rb, 2))
      else $error("port A address lines driven without readback");
endmodule

//--- test/dpsr_master.sv
// Pin-level bus master model for one RAM port
module dpsr_master (
   // Clock
   input wire clk,
   // Port pins
   output reg [18:0] addr,
   output reg [17:0] data,
   output reg [1:0] ben_n,
   output reg rw,
   output reg strobe_n,
   output reg cnt_n,
   output reg crst_n,
   output reg msel,
   output reg rb_n,
   output reg rt_n,
   output reg ce_l,
   output reg ce_h
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {rw, strobe_n, cnt_n, crst_n, msel, rb_n, rt_n, ce_l, ce_h} = 9'h1ed;
      addr = 19'h0;
      data = 18'h0;
      ben_n = 2'h0;
   end
   // One request held until the next call, launched right after an edge
   task op(input [8:0] c, input [18:0] a = 19'h0, input [17:0] d = 18'h0,
      input [1:0] be = 2'h0);
      @(posedge clk);
      {rw, strobe_n, cnt_n, crst_n, msel, rb_n, rt_n, ce_l, ce_h} <= c;
      addr <= a;
      // Data lines not written this cycle carry junk, never the last word
      data <= c[8] ? ~data : d;
      ben_n <= be;
   endtask
endmodule

//--- test/dpsr_top_tb.sv
// Self-checking bench of the dual-port RAM through its pins and status registers
`include "dpsr_defs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module dpsr_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [8:0] IDL = 9'h1ed, RD_LD = 9'h16d, WR_LD = 9'h06d, WR_INC = 9'h0ad;
   localparam [8:0] RD_INC = 9'h1ad, MSK_LD = 9'h17d, RB_CNT = 9'h1e5, RB_MSK = 9'h1f5;
   localparam [8:0] RT = 9'h1e9, CRST = 9'h1cd, MSK_RST = 9'h1dd, PD = 9'h1ec;
   integer failures = 0, checks = 0, i;
   reg clk, rst = 1'h1, global_async_reset = 1'h0;
   reg [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'h0;
   reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [18:0] a_addr_in, a_addr_out, b_addr_in, b_addr_out;
   wire [17:0] a_data_in, a_data_out, b_data_in, b_data_out;
   wire [1:0] a_byte_en_n, b_byte_en_n;
   wire a_addr_oe, a_data_oe, a_read_write, a_chip_enable_active_low;
   wire a_chip_enable_active_high, a_address_strobe_n, a_count_enable_n, a_counter_reset_n;
   wire a_mask_select, a_readback_n, a_retransmit_n, a_counter_wrap_flag;
   wire b_addr_oe, b_data_oe, b_read_write, b_chip_enable_active_low;
   wire b_chip_enable_active_high, b_address_strobe_n, b_count_enable_n, b_counter_reset_n;
   wire b_mask_select, b_readback_n, b_retransmit_n, b_counter_wrap_flag;
   dpsr_top #(.AW(19)) dpsr_top_inst (.*);
   dpsr_master ma (.clk, .addr(a_addr_in), .data(a_data_in), .ben_n(a_byte_en_n),
      .rw(a_read_write), .strobe_n(a_address_strobe_n), .cnt_n(a_count_enable_n),
      .crst_n(a_counter_reset_n), .msel(a_mask_select), .rb_n(a_readback_n),
      .rt_n(a_retransmit_n), .ce_l(a_chip_enable_active_low), .ce_h(a_chip_enable_active_high));
   dpsr_master mb (.clk, .addr(b_addr_in), .data(b_data_in), .ben_n(b_byte_en_n),
      .rw(b_read_write), .strobe_n(b_address_strobe_n), .cnt_n(b_count_enable_n),
      .crst_n(b_counter_reset_n), .msel(b_mask_select), .rb_n(b_readback_n),
      .rt_n(b_retransmit_n), .ce_l(b_chip_enable_active_low), .ce_h(b_chip_enable_active_high));
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   task wrap_up;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task axw(input [7:0] a, input [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (i = 0; i < 20 && !(s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid); i++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) s_axi_bready <= 1'h0;
      end
      if (i == 20) begin
         failures++;
         wrap_up;
      end
   endtask
   task axr(input [7:0] a, output [31:0] d, output [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (i = 0; i < 20 && !(s_axi_rvalid && !s_axi_arvalid); i++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         d = s_axi_rdata;
         r = s_axi_rresp;
         if (s_axi_rvalid) s_axi_rready <= 1'h0;
      end
      if (i == 20) begin
         failures++;
         wrap_up;
      end
   endtask
   task settle(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task rdq(input [8:0] c, input [18:0] a, input [17:0] e);
      ma.op(c, a);
      ma.op(IDL);
      settle(1);
      `CHK("a data", e, a_data_out);
      `CHK("a data oe", 1'h1, a_data_oe);
   endtask
   task rb(input [8:0] c, input [18:0] e);
      ma.op(c);
      ma.op(IDL);
      settle(1);
      `CHK("a readback", e, a_addr_out);
      `CHK("a addr oe", 1'h1, a_addr_oe);
   endtask
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      fork
         ma.op(WR_LD, 19'h10, 18'h2a5a5, 2'h0);
         mb.op(RD_LD, 19'h10);
      join
      ma.op(WR_LD, 19'h10, 18'h15a5a, 2'h2);
      fork
         ma.op(IDL);
         mb.op(IDL);
      join
      settle(1);
      `CHK("b data", 18'h2a5a5, b_data_out);
      settle(1);
      `CHK("b lanes", 18'h2a45a, b_data_out);
      `CHK("a lanes", 18'h2a45a, a_data_out);
      ma.op(MSK_LD, 19'h3);
      ma.op(RD_LD, 19'h20);
      for (int k = 0; k < 4; k++) ma.op(WR_INC, 19'h0, 18'h100 + 18'(k));
      ma.op(IDL);
      settle(1);
      `CHK("a wrap", 1'h1, a_counter_wrap_flag);
      rb(RB_CNT, 19'h20);
      rb(RB_MSK, 19'h3);
      rdq(RD_INC, 19'h0, 18'h100);
      rdq(IDL, 19'h0, 18'h101);
      rdq(RT, 19'h0, 18'h100);
      `CHK("a wrap held", 1'h1, a_counter_wrap_flag);
      rdq(RD_LD, 19'h21, 18'h101);
      `CHK("a wrap clear", 1'h0, a_counter_wrap_flag);
      ma.op(CRST);
      rb(RB_CNT, 19'h0);
      ma.op(MSK_RST);
      rb(RB_MSK, 19'h7ffff);
      fork
         ma.op(PD);
         mb.op(PD);
      join
      settle(3);
      `CHK("a pd oe", 1'h0, a_data_oe);
      `CHK("b pd oe", 1'h0, b_data_oe);
      axr(`DPSR_OFS_PORT_STATE, d, r);
      `CHK("pd state", 1'h1, d[`DPSR_ST_PD_A]);
      `CHK("b pd state", 1'h1, d[`DPSR_ST_PD_B]);
      ma.op(IDL);
      settle(1);
      axr(`DPSR_OFS_PORT_STATE, d, r);
      `CHK("pd state", 1'h0, d[`DPSR_ST_PD_A]);
      `CHK("b pd held", 1'h1, d[`DPSR_ST_PD_B]);
      `CHK("a oe back", 1'h1, a_data_oe);
      axw(`DPSR_OFS_IRQ_MASK, 32'h0);
      mb.op(MSK_LD, 19'h1);
      mb.op(RD_LD, 19'h1);
      mb.op(RD_INC);
      mb.op(IDL);
      settle(3);
      `CHK("b wrap", 1'h1, b_counter_wrap_flag);
      `CHK("irq masked", 1'h0, irq);
      axr(`DPSR_OFS_STATUS, d, r);
      `CHK("status", 32'h3, d);
      axw(`DPSR_OFS_IRQ_MASK, 32'h2);
      settle(2);
      `CHK("irq", 1'h1, irq);
      axw(`DPSR_OFS_STATUS, 32'h2);
      settle(2);
      `CHK("irq cleared", 1'h0, irq);
      axr(`DPSR_OFS_STATUS, d, r);
      `CHK("status", 32'h1, d);
      axr(8'h0c, d, r);
      `CHK("unmapped resp", `DPSR_RESP_SLVERR, r);
      `CHK("unmapped data", 32'h0, d);
      axw(8'h0c, 32'h0);
      `CHK("unmapped bresp", `DPSR_RESP_SLVERR, s_axi_bresp);
      // The reset rises after the edge, so only an asynchronous path clears the flag
      @(posedge clk);
      global_async_reset <= 1'h1;
      #1;
      `CHK("b wrap async", 1'h0, b_counter_wrap_flag);
      `CHK("b oe async", 1'h0, b_data_oe);
      @(posedge clk);
      global_async_reset <= 1'h0;
      rb(RB_CNT, 19'h0);
      mb.op(RB_MSK);
      mb.op(IDL);
      settle(1);
      `CHK("b mask async", 19'h7ffff, b_addr_out);
      `CHK("b addr oe", 1'h1, b_addr_oe);
      wrap_up;
   end
endmodule
bind dpsr_top dpsr_checker dpsr_checker_inst (.*);
